// file: srp_defines.vh
// Constants for the suspend/resume power controller
`ifndef SRP_DEFINES_VH
`define SRP_DEFINES_VH
`define SRP_ADDR_W 10
`define SRP_OFF_HOST_CMD 10'h020
`define SRP_OFF_HW_CONFIG 10'h300
`define SRP_OFF_INT_STATUS 10'h310
`define SRP_OFF_POWER_DOWN 10'h354
`define SRP_OFF_PORT_CTRL 10'h380
`define SRP_OFF_PWR_STATUS 10'h384
`define SRP_RST_HOST_CMD 32'h00080000
`define SRP_RST_HW_CONFIG 32'h00000000
`define SRP_RST_POWER_DOWN 32'h03E81BA0
`define SRP_RUN_STOP_BIT 0
`define SRP_OC_DIGITAL_BIT 15
`define SRP_CLK_OFF_MSB 31
`define SRP_CLK_OFF_LSB 16
`define SRP_INT_CLK_RDY_BIT 0
`define SRP_INT_OC_LSB 1
`define SRP_INT_WAKE_BIT 4
`define SRP_CTRL_SUSPEND_BIT 8
`define SRP_NPORTS 3
`define SRP_CLK_PERIOD_NS 8
`define SRP_SLOW_TICK_NS 10000
`define SRP_SLOW_TICK_CYC ((`SRP_SLOW_TICK_NS + `SRP_CLK_PERIOD_NS - 1) / `SRP_CLK_PERIOD_NS)
`define SRP_POR_PULSE_NS 800
`define SRP_POR_PULSE_CYC ((`SRP_POR_PULSE_NS + `SRP_CLK_PERIOD_NS - 1) / `SRP_CLK_PERIOD_NS)
`define SRP_DIP_NS 11000
`define SRP_DIP_CYC ((`SRP_DIP_NS + `SRP_CLK_PERIOD_NS - 1) / `SRP_CLK_PERIOD_NS)
`define SRP_CLK_SETTLE_NS 50000
`define SRP_OC_FILTER_NS 2000000
`define SRP_REF_TIMEOUT_CYC 31
`define SRP_MAIN_MHZ 8'h7D
`define SRP_F30_MHZ 7'h1E
`define SRP_F48_MHZ 7'h30
`define SRP_F60_MHZ 7'h3C
`endif

// file: srp_oc_filter.v
// Debounce filter for one overcurrent indication
`timescale 1ns/1ps
`default_nettype none
module srp_oc_filter #(
   parameter FILT_CYC = 250000
) (
   input wire clk_i,
   input wire rst_i,
   input wire raw_i,
   output reg filt_o
);
   reg [17:0] cnt_q;

   // Output follows the input only after it held a new level for FILT_CYC cycles
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cnt_q <= 18'h00000;
         filt_o <= 1'b0;
      end
      else if (raw_i == filt_o)
      begin
         cnt_q <= 18'h00000;
      end
      else if (cnt_q >= FILT_CYC[17:0] - 18'h00001)
      begin
         cnt_q <= 18'h00000;
         filt_o <= raw_i;
      end
      else
      begin
         cnt_q <= cnt_q + 18'h00001;
      end
   end
endmodule
`default_nettype wire

// file: srp_power_ctrl.v
// Suspend/resume, clocking, overcurrent and power-on reset control
// Operation
// - Main 30, 48 and 60 MHz clocks derive from the 125 MHz system clock, enabled while the 12 MHz reference runs.
// - Suspend stops main clocks; 100 kHz keep-alive clock keeps running.
// - Port attach or detach while suspended starts a resume.
// - Chip-select assertion while suspended starts a resume.
// - Low wake pin while suspended starts a wake-up; high does nothing.
// - Wake pin driven low while awake, released while suspended.
// - Resume state lasts the clock-off count in power-down bits 31:16.
// - Run/stop set during resume gives permanent normal operation.
// - Run/stop still clear at count expiry returns to suspend.
// - Power-down register lets software disable internal blocks.
// - Each wake-up restarts clocks and raises clock-ready once running.
// - Hardware config bit 15 picks analog or digital overcurrent input.
// - Digital overcurrent input removes that port's power by itself.
// - Overcurrent indications pass a 1 to 3 ms filter.
// - Power-on reset pulse of 800 ns after supply passes trip level.
// - Supply dips longer than 11 us regenerate the reset; shorter ignored.
// - Wake-up back to suspend takes about 10 ms with power on.
// - Writing 1 to a set interrupt status bit clears it.
`timescale 1ns/1ps
`default_nettype none
`include "srp_defines.vh"
module srp_power_ctrl #(
   parameter CLK_SETTLE_CYC = `SRP_CLK_SETTLE_NS / `SRP_CLK_PERIOD_NS,
   parameter OC_FILTER_CYC = `SRP_OC_FILTER_NS / `SRP_CLK_PERIOD_NS
) (
   input wire clk_i,
   input wire rst_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [`SRP_ADDR_W-1:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire ref_clock_input_i,
   input wire vcc_ok_i,
   input wire cs_n_i,
   input wire [2:0] port_connect_i,
   input wire [2:0] overcurrent_flag_in_n_i,
   input wire [2:0] analog_trip_i,
   input wire sleep_wake_pin_i,
   output wire sleep_wake_pin_o,
   output wire sleep_wake_pin_oe_o,
   output wire [2:0] port_power_enable_n_o,
   output wire main_clk_en_o,
   output wire [2:0] clk_tick_o,
   output reg slow_keepalive_clock_o,
   output reg clk_ready_o,
   output wire [15:0] blk_disable_o,
   output reg por_o
);
   localparam [3:0] ST_RUN = 4'h1;
   localparam [3:0] ST_SUSP = 4'h2;
   localparam [3:0] ST_WAKE = 4'h4;
   localparam [3:0] ST_RESUME = 4'h8;
   localparam NSYNC = 13;

   reg [NSYNC-1:0] sync1_q;
   reg [NSYNC-1:0] sync2_q;
   reg ref_prev_q;
   reg [4:0] ref_idle_q;
   reg ref_alive_q;
   reg [2:0] conn_prev_q;
   reg [3:0] state_q;
   reg [3:0] state_d;
   reg [15:0] resume_cnt_q;
   reg [12:0] settle_cnt_q;
   reg [10:0] slow_cnt_q;
   reg slow_tick_q;
   reg [31:0] host_cmd_q;
   reg [31:0] hw_config_q;
   reg [31:0] power_down_q;
   reg [4:0] int_status_q;
   reg [2:0] port_pwr_q;
   reg suspend_req_q;
   reg [10:0] dip_cnt_q;
   reg dip_long_q;
   reg [6:0] por_cnt_q;
   reg [6:0] acc_q [0:2];
   reg [2:0] tick_q;
   // Own drive of the wake pin, aged by the synchroniser depth
   reg [1:0] drv_hist_q;
   wire sys_rst;
   wire ref_s;
   wire vcc_s;
   wire cs_n_s;
   wire wake_n_s;
   wire [2:0] conn_s;
   wire [2:0] oc_n_s;
   wire [2:0] oc_raw;
   wire [2:0] oc_filt;
   wire [2:0] oc_event;
   wire wake_evt;
   wire clocks_on;
   wire wb_req;
   wire [31:0] wmask;
   wire [4:0] int_set;
   genvar gi;

   assign sys_rst = rst_i | por_o;
   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   // Two-stage synchronisers for every pin input
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sync1_q <= 13'h1FFF;
         sync2_q <= 13'h1FFF;
      end
      else
      begin
         sync1_q <= {analog_trip_i, overcurrent_flag_in_n_i, port_connect_i,
            sleep_wake_pin_i, cs_n_i, vcc_ok_i, ref_clock_input_i};
         sync2_q <= sync1_q;
      end
   end
   assign ref_s = sync2_q[0];
   assign vcc_s = sync2_q[1];
   assign cs_n_s = sync2_q[2];
   assign wake_n_s = sync2_q[3];
   assign conn_s = sync2_q[6:4];
   assign oc_n_s = sync2_q[9:7];

   // Supply dip detector and power-on reset pulse stretcher
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         dip_cnt_q <= 11'h000;
         dip_long_q <= 1'b0;
         por_cnt_q <= 7'h00;
         por_o <= 1'b1;
      end
      else
      begin
         if (vcc_s)
         begin
            dip_cnt_q <= 11'h000;
            dip_long_q <= 1'b0;
         end
         else if (dip_cnt_q >= `SRP_DIP_CYC)
         begin
            dip_long_q <= 1'b1;
         end
         else
         begin
            dip_cnt_q <= dip_cnt_q + 11'h001;
         end
         if (dip_long_q)
         begin
            por_o <= 1'b1;
            por_cnt_q <= 7'h00;
         end
         else if (por_o && vcc_s)
         begin
            if (por_cnt_q >= `SRP_POR_PULSE_CYC - 1)
               por_o <= 1'b0;
            else
               por_cnt_q <= por_cnt_q + 7'h01;
         end
      end
   end

   // Reference presence: edges of the 12 MHz input must keep arriving
   always @(posedge clk_i)
   begin
      if (sys_rst)
      begin
         ref_prev_q <= 1'b0;
         ref_idle_q <= 5'h00;
         ref_alive_q <= 1'b0;
      end
      else
      begin
         ref_prev_q <= ref_s;
         if (ref_s != ref_prev_q)
         begin
            ref_idle_q <= 5'h00;
            ref_alive_q <= 1'b1;
         end
         else if (ref_idle_q == `SRP_REF_TIMEOUT_CYC)
            ref_alive_q <= 1'b0;
         else
            ref_idle_q <= ref_idle_q + 5'h01;
      end
   end

   // Main clock enables are gated off in suspend and without a reference
   assign clocks_on = ref_alive_q & (state_q != ST_SUSP) & (state_q != ST_WAKE);
   assign main_clk_en_o = clocks_on;
   assign clk_tick_o = tick_q;

   // Phase accumulators yielding 30, 48 and 60 MHz tick strobes
   generate
      for (gi = 0; gi < 3; gi = gi + 1)
      begin : g_acc
         wire [6:0] rate;
         wire [7:0] sum;
         wire [7:0] wrap;
         assign rate = (gi == 0) ? `SRP_F30_MHZ : ((gi == 1) ? `SRP_F48_MHZ : `SRP_F60_MHZ);
         assign sum = {1'b0, acc_q[gi]} + {1'b0, rate};
         assign wrap = sum - `SRP_MAIN_MHZ;
         always @(posedge clk_i)
         begin
            if (sys_rst || !clocks_on)
            begin
               acc_q[gi] <= 7'h00;
               tick_q[gi] <= 1'b0;
            end
            else if (sum >= `SRP_MAIN_MHZ)
            begin
               acc_q[gi] <= wrap[6:0];
               tick_q[gi] <= 1'b1;
            end
            else
            begin
               acc_q[gi] <= sum[6:0];
               tick_q[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // Free-running 100 kHz keep-alive clock; its ticks pace the resume window
   always @(posedge clk_i)
   begin
      if (sys_rst)
      begin
         slow_cnt_q <= 11'h000;
         slow_tick_q <= 1'b0;
         slow_keepalive_clock_o <= 1'b0;
      end
      else if (slow_cnt_q >= `SRP_SLOW_TICK_CYC - 1)
      begin
         slow_cnt_q <= 11'h000;
         slow_tick_q <= 1'b1;
         slow_keepalive_clock_o <= 1'b0;
      end
      else
      begin
         slow_cnt_q <= slow_cnt_q + 11'h001;
         slow_tick_q <= 1'b0;
         if (slow_cnt_q == (`SRP_SLOW_TICK_CYC / 2))
            slow_keepalive_clock_o <= 1'b1;
      end
   end

   // Wake sources, honoured only in suspend
   assign wake_evt = (state_q == ST_SUSP) &
      ((conn_s != conn_prev_q) |
      ~cs_n_s |
      (~wake_n_s & ~drv_hist_q[1]));

   // Wake pin: driven low while awake, released until the clocks are back
   assign sleep_wake_pin_o = 1'b0;
   assign sleep_wake_pin_oe_o = (state_q != ST_SUSP) & (state_q != ST_WAKE);

   // Power state sequencing
   always @*
   begin
      state_d = state_q;
      case (state_q)
         ST_RUN:
            if (suspend_req_q)
               state_d = ST_SUSP;
         ST_SUSP:
            if (wake_evt)
               state_d = ST_WAKE;
         ST_WAKE:
            if (settle_cnt_q >= CLK_SETTLE_CYC - 1 && ref_alive_q)
               state_d = ST_RESUME;
         ST_RESUME:
            if (host_cmd_q[`SRP_RUN_STOP_BIT])
               state_d = ST_RUN;
            else if (slow_tick_q && resume_cnt_q <= 16'h0001)
               state_d = ST_SUSP;
         default:
            state_d = ST_RUN;
      endcase
   end

   always @(posedge clk_i)
   begin
      if (sys_rst)
      begin
         state_q <= ST_RUN;
         settle_cnt_q <= 13'h0000;
         resume_cnt_q <= 16'h0000;
         conn_prev_q <= 3'h0;
         drv_hist_q <= 2'b11;
      end
      else
      begin
         state_q <= state_d;
         conn_prev_q <= conn_s;
         // Our own low drive must leave the synchroniser before the pin counts
         drv_hist_q <= {drv_hist_q[0], sleep_wake_pin_oe_o};
         if (state_q == ST_WAKE)
            settle_cnt_q <= settle_cnt_q + 13'h0001;
         else
            settle_cnt_q <= 13'h0000;
         if (state_d == ST_RESUME && state_q != ST_RESUME)
            resume_cnt_q <= power_down_q[`SRP_CLK_OFF_MSB:`SRP_CLK_OFF_LSB];
         else if (state_q == ST_RESUME && slow_tick_q && resume_cnt_q != 16'h0000)
            resume_cnt_q <= resume_cnt_q - 16'h0001;
      end
   end

   // Overcurrent source select and filters, one per port
   assign oc_raw = hw_config_q[`SRP_OC_DIGITAL_BIT] ? ~oc_n_s : sync2_q[12:10];
   generate
      for (gi = 0; gi < `SRP_NPORTS; gi = gi + 1)
      begin : g_oc
         srp_oc_filter #(
            .FILT_CYC(OC_FILTER_CYC)
         ) u_filt (
            .clk_i(clk_i),
            .rst_i(sys_rst),
            .raw_i(oc_raw[gi]),
            .filt_o(oc_filt[gi])
         );
      end
   endgenerate
   // Power switch cut off on a filtered overcurrent, no software needed
   assign port_power_enable_n_o = ~(port_pwr_q & ~oc_filt);

   // Status event sources
   assign oc_event = oc_filt;
   assign int_set = {wake_evt, oc_event, (state_q == ST_WAKE) && (state_d == ST_RESUME)};
   assign blk_disable_o = power_down_q[15:0];

   // Wishbone slave: one-cycle ack, registers, write-one-to-clear status
   always @(posedge clk_i)
   begin
      if (sys_rst)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
         host_cmd_q <= `SRP_RST_HOST_CMD;
         hw_config_q <= `SRP_RST_HW_CONFIG;
         power_down_q <= `SRP_RST_POWER_DOWN;
         int_status_q <= 5'h00;
         port_pwr_q <= 3'h0;
         suspend_req_q <= 1'b0;
         clk_ready_o <= 1'b0;
      end
      else
      begin
         wb_ack_o <= wb_req;
         suspend_req_q <= 1'b0;
         // Set wins over a simultaneous clear
         if (wb_req && wb_we_i && wb_adr_i == `SRP_OFF_INT_STATUS && wb_sel_i[0])
            int_status_q <= (int_status_q & ~wb_dat_i[4:0]) | int_set;
         else
            int_status_q <= int_status_q | int_set;
         clk_ready_o <= int_status_q[`SRP_INT_CLK_RDY_BIT];
         if (wb_req && wb_we_i)
         begin
            if (wb_adr_i == `SRP_OFF_HOST_CMD)
               host_cmd_q <= (host_cmd_q & ~wmask) | (wb_dat_i & wmask);
            else if (wb_adr_i == `SRP_OFF_HW_CONFIG)
               hw_config_q <= (hw_config_q & ~wmask) | (wb_dat_i & wmask);
            else if (wb_adr_i == `SRP_OFF_POWER_DOWN)
               power_down_q <= (power_down_q & ~wmask) | (wb_dat_i & wmask);
            else if (wb_adr_i == `SRP_OFF_PORT_CTRL && wb_sel_i[1])
            begin
               if (wb_sel_i[0])
                  port_pwr_q <= wb_dat_i[2:0];
               suspend_req_q <= wb_dat_i[`SRP_CTRL_SUSPEND_BIT];
            end
            else if (wb_adr_i == `SRP_OFF_PORT_CTRL && wb_sel_i[0])
               port_pwr_q <= wb_dat_i[2:0];
         end
         // Read data; unmapped addresses read zero
         if (wb_req && !wb_we_i)
         begin
            if (wb_adr_i == `SRP_OFF_HOST_CMD)
               wb_dat_o <= host_cmd_q;
            else if (wb_adr_i == `SRP_OFF_HW_CONFIG)
               wb_dat_o <= hw_config_q;
            else if (wb_adr_i == `SRP_OFF_INT_STATUS)
               wb_dat_o <= {27'h0000000, int_status_q};
            else if (wb_adr_i == `SRP_OFF_POWER_DOWN)
               wb_dat_o <= power_down_q;
            else if (wb_adr_i == `SRP_OFF_PORT_CTRL)
               wb_dat_o <= {29'h00000000, port_pwr_q};
            else if (wb_adr_i == `SRP_OFF_PWR_STATUS)
               wb_dat_o <= {9'h000, resume_cnt_q, oc_filt, state_q};
            else
               wb_dat_o <= 32'h00000000;
         end
      end
   end
endmodule
`default_nettype wire

// file: srp_power_ctrl_monitor.sv
// Assertion checker for the suspend/resume power controller
`timescale 1ns/1ps
`default_nettype none
module srp_power_ctrl_monitor #(
   parameter CLK_SETTLE_CYC = 6250,
   parameter OC_FILTER_CYC = 250000
) (
   input wire clk_i,
   input wire rst_i,
   input wire vcc_ok_i,
   input wire cs_n_i,
   input wire [2:0] port_connect_i,
   input wire sleep_wake_pin_i,
   input wire sleep_wake_pin_o,
   input wire sleep_wake_pin_oe_o,
   input wire main_clk_en_o,
   input wire [2:0] clk_tick_o,
   input wire slow_keepalive_clock_o,
   input wire clk_ready_o,
   input wire por_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   reg slow_prev_q;
   reg [10:0] slow_q;
   reg [10:0] vlo_q;
   reg [7:0] vhi_q;
   // Cycles since the last keep-alive edge, and saturating supply run lengths
   always @(posedge clk_i)
   begin
      slow_prev_q <= slow_keepalive_clock_o;
      slow_q <= (rst_i || por_o || slow_prev_q != slow_keepalive_clock_o) ? 11'h000 :
         slow_q + 11'h001;
      vlo_q <= vcc_ok_i ? 11'h000 : ((vlo_q == 11'h7FF) ? vlo_q : vlo_q + 11'h001);
      vhi_q <= (!vcc_ok_i || rst_i) ? 8'h00 : ((vhi_q == 8'hFF) ? vhi_q : vhi_q + 8'h01);
   end
   property p_pin_drv;
      sleep_wake_pin_oe_o |-> !sleep_wake_pin_o;
   endproperty
   a_pin_drv: assert property (p_pin_drv) else $error("wake pin driven high");
   property p_clk_stop;
      !sleep_wake_pin_oe_o && !$past(sleep_wake_pin_oe_o) |-> !main_clk_en_o && clk_tick_o == 3'h0;
   endproperty
   a_clk_stop: assert property (p_clk_stop) else $error("main clocks run asleep");
   property p_keepalive;
      slow_q < 11'h320;
   endproperty
   a_keepalive: assert property (p_keepalive) else $error("keep-alive clock stuck");
   property p_wake_cs;
      !sleep_wake_pin_oe_o && !cs_n_i |-> ##[1:30] sleep_wake_pin_oe_o;
   endproperty
   a_wake_cs: assert property (p_wake_cs) else $error("no resume on select");
   property p_wake_pin;
      !sleep_wake_pin_oe_o && !sleep_wake_pin_i |-> ##[1:30] sleep_wake_pin_oe_o;
   endproperty
   a_wake_pin: assert property (p_wake_pin) else $error("no resume on wake pin");
   property p_wake_conn;
      !sleep_wake_pin_oe_o && $changed(port_connect_i) |-> ##[1:30] sleep_wake_pin_oe_o;
   endproperty
   a_wake_conn: assert property (p_wake_conn) else $error("no resume on attach");
   property p_ready;
      $rose(sleep_wake_pin_oe_o) && !por_o |=> clk_ready_o;
   endproperty
   a_ready: assert property (p_ready) else $error("clock ready missing");
   property p_por_dip;
      $rose(por_o) |-> vlo_q > 11'h514;
   endproperty
   a_por_dip: assert property (p_por_dip) else $error("reset on short dip");
   property p_por_width;
      $fell(por_o) |-> vhi_q >= 8'h64;
   endproperty
   a_por_width: assert property (p_por_width) else $error("reset pulse short");
   property p_por_end;
      vhi_q == 8'h78 |-> !por_o;
   endproperty
   a_por_end: assert property (p_por_end) else $error("reset pulse long");
endmodule
bind srp_power_ctrl srp_power_ctrl_monitor #(
   .CLK_SETTLE_CYC(CLK_SETTLE_CYC),
   .OC_FILTER_CYC(OC_FILTER_CYC)
) i_srp_power_ctrl_monitor (
   .clk_i(clk_i), .rst_i(rst_i), .vcc_ok_i(vcc_ok_i), .cs_n_i(cs_n_i),
   .port_connect_i(port_connect_i), .sleep_wake_pin_i(sleep_wake_pin_i),
   .sleep_wake_pin_o(sleep_wake_pin_o), .sleep_wake_pin_oe_o(sleep_wake_pin_oe_o),
   .main_clk_en_o(main_clk_en_o), .clk_tick_o(clk_tick_o),
   .slow_keepalive_clock_o(slow_keepalive_clock_o), .clk_ready_o(clk_ready_o), .por_o(por_o)
);
`default_nettype wire

// file: srp_far_side_model.sv
// Far-side model: host GPIO line on the wake pin and port power switches
`timescale 1ns/1ps
`default_nettype none
module srp_far_side_model (
   input wire logic dev_oe_i,
   input wire logic dev_o_i,
   input wire logic gpio_low_i,
   input wire logic [2:0] fault_i,
   output logic wake_pin_o,
   output logic [2:0] oc_n_o
);
   // Pull-up holds the pin high unless the device or the GPIO line pulls it low
   assign wake_pin_o = !((dev_oe_i && !dev_o_i) || gpio_low_i);
   // Power switches flag a port fault on an active-low line
   assign oc_n_o = ~fault_i;
endmodule
`default_nettype wire

// file: srp_power_ctrl_test.sv
// Self-checking bench for the suspend/resume power controller
`timescale 1ns/1ps
`default_nettype none
`include "srp_defines.vh"
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin miscompares++; $display("CHECK FAILED %s exp %h got %h", nm, ex, gt); end end
module srp_power_ctrl_test;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ref_clk = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [9:0] adr = 10'h000;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic vcc = 1'b1;
   logic cs_n = 1'b1;
   logic gpio_low = 1'b0;
   logic [2:0] conn = 3'h0;
   logic [2:0] fault = 3'h0;
   logic [2:0] ana = 3'h0;
   wire [31:0] wb_dat_o;
   wire wb_ack_o, pin, pin_o, pin_oe, clk_en, slow, rdy, por;
   wire [2:0] oc_n, pwr_n, tick;
   wire [15:0] blk;
   int miscompares = 0;
   int checks_done = 0;
   int n, t0;
   int now = 0;
   int cnt [3];
   int rate [3] = '{300, 480, 600};
   srp_power_ctrl #(.CLK_SETTLE_CYC(20), .OC_FILTER_CYC(16)) i_srp_power_ctrl (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .ref_clock_input_i(ref_clk), .vcc_ok_i(vcc), .cs_n_i(cs_n),
      .port_connect_i(conn), .overcurrent_flag_in_n_i(oc_n), .analog_trip_i(ana),
      .sleep_wake_pin_i(pin), .sleep_wake_pin_o(pin_o), .sleep_wake_pin_oe_o(pin_oe),
      .port_power_enable_n_o(pwr_n), .main_clk_en_o(clk_en), .clk_tick_o(tick),
      .slow_keepalive_clock_o(slow), .clk_ready_o(rdy), .blk_disable_o(blk), .por_o(por));
   srp_far_side_model i_srp_far_side_model (.dev_oe_i(pin_oe), .dev_o_i(pin_o),
      .gpio_low_i(gpio_low), .fault_i(fault), .wake_pin_o(pin), .oc_n_o(oc_n));
   // System clock, unrelated 12 MHz reference and a cycle count
   always #4 clk_i = ~clk_i;
   always #41.667 ref_clk = ~ref_clk;
   always @(posedge clk_i) now <= now + 1;
   // Counts, verdict and end of run
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // One classic Wishbone cycle; read data lands in rdat
   task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1 && t < 20)
      begin
         @(posedge clk_i);
         t++;
      end
      rdat = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (t == 20)
         miscompares++;
   endtask
   task automatic idle(input int c);
      repeat (c) @(posedge clk_i);
   endtask
   // Bounded wait for the reset pulse or the wake pin enable to reach a level
   task automatic wait_for(input bit use_por, input logic v, input int lim);
      n = 0;
      while ((use_por ? por : pin_oe) !== v && n < lim)
      begin
         @(posedge clk_i);
         n++;
      end
      if (n == lim)
         miscompares++;
   endtask
   // Main sequence
   initial
   begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      wait_for(1, 1'b0, 300);
      `CHK("por width", 1'b1, n >= 100 && n <= 112)
      wb(0, `SRP_OFF_POWER_DOWN, 0);
      `CHK("pwr dn rst", 32'h03E81BA0, rdat)
      `CHK("blk rst", 16'h1BA0, blk)
      wb(0, `SRP_OFF_HOST_CMD, 0);
      `CHK("cmd rst", 32'h00080000, rdat)
      wb(0, 10'h004, 0);
      `CHK("unmapped", 32'h0, rdat)
      `CHK("clk run", 1'b1, clk_en)
      cnt = '{0, 0, 0};
      repeat (1250)
      begin
         @(posedge clk_i);
         for (int b = 0; b < 3; b++)
            cnt[b] += tick[b];
      end
      for (int b = 0; b < 3; b++)
         `CHK("tick rate", 1'b1, cnt[b] >= rate[b] - 6 && cnt[b] <= rate[b] + 6)
      wb(1, `SRP_OFF_POWER_DOWN, 32'h000400FF);
      idle(3);
      `CHK("blk set", 16'h00FF, blk)
      cs_n <= 1'b0;
      gpio_low <= 1'b1;
      idle(40);
      `CHK("run ignores wake", 1'b1, pin_oe)
      cs_n <= 1'b1;
      gpio_low <= 1'b0;
      wb(0, `SRP_OFF_INT_STATUS, 0);
      `CHK("no wake flag", 1'b0, rdat[4])
      wb(1, `SRP_OFF_PORT_CTRL, 32'h00000100);
      idle(2);
      `CHK("susp oe", 1'b0, pin_oe)
      `CHK("susp pin", 1'b1, pin)
      `CHK("susp clk", 1'b0, clk_en)
      idle(50);
      `CHK("pin high", 1'b0, pin_oe)
      // Wake by pin, by attach, by select; the last one is kept by run/stop
      for (int s = 0; s < 3; s++)
      begin
         gpio_low <= (s == 0);
         conn <= (s == 1) ? 3'h1 : conn;
         cs_n <= (s != 2);
         wait_for(0, 1'b1, 100);
         t0 = now;
         `CHK("wake time", 1'b1, n <= 30)
         @(posedge clk_i);
         `CHK("clk ready", 1'b1, rdy)
         `CHK("clk back", 1'b1, clk_en)
         gpio_low <= 1'b0;
         cs_n <= 1'b1;
         wb(0, `SRP_OFF_INT_STATUS, 0);
         `CHK("wake flags", 5'h11, rdat[4:0] & 5'h11)
         wb(1, `SRP_OFF_INT_STATUS, 32'h11);
         wb(0, `SRP_OFF_INT_STATUS, 0);
         `CHK("w1c", 5'h00, rdat[4:0] & 5'h11)
         if (s < 2)
         begin
            wait_for(0, 1'b0, 6000);
            `CHK("window", 1'b1, now - t0 >= 2400 && now - t0 <= 5100)
         end
         else
         begin
            wb(1, `SRP_OFF_HOST_CMD, 32'h00080001);
            idle(6000);
            `CHK("stay run", 1'b1, pin_oe)
            wb(0, `SRP_OFF_PWR_STATUS, 0);
            `CHK("state run", 4'h1, rdat[3:0])
         end
      end
      // Overcurrent: mode select, cut-off and the inrush filter
      wb(1, `SRP_OFF_PORT_CTRL, 32'h00000007);
      wb(1, `SRP_OFF_HW_CONFIG, 32'h00008000);
      idle(3);
      `CHK("ports on", 3'h0, pwr_n)
      ana <= 3'h1;
      fault <= 3'h2;
      idle(30);
      `CHK("digital cut", 3'h2, pwr_n)
      fault <= 3'h6;
      idle(8);
      fault <= 3'h2;
      idle(30);
      `CHK("short pulse", 3'h2, pwr_n)
      wb(1, `SRP_OFF_HW_CONFIG, 32'h0);
      idle(40);
      `CHK("analog cut", 3'h1, pwr_n)
      wb(0, `SRP_OFF_INT_STATUS, 0);
      `CHK("oc flags", 3'h3, rdat[3:1])
      // Supply dips: short ones ignored, long ones restart the reset pulse
      vcc <= 1'b0;
      idle(200);
      vcc <= 1'b1;
      idle(10);
      `CHK("short dip", 1'b0, por)
      vcc <= 1'b0;
      idle(1500);
      `CHK("long dip", 1'b1, por)
      vcc <= 1'b1;
      // Full-width reset pulse and register reset after a reset input pulse at supply restore
      rst_i <= 1'b1;
      idle(6);
      rst_i <= 1'b0;
      wait_for(1, 1'b0, 300);
      `CHK("por width", 1'b1, n >= 100 && n <= 112)
      wb(0, `SRP_OFF_POWER_DOWN, 0);
      `CHK("por clears", 32'h03E81BA0, rdat)
      end_of_test;
   end
   // Cut a hang short
   initial
   begin
      repeat (60000) @(posedge clk_i);
      miscompares++;
      end_of_test;
   end
endmodule
`default_nettype wire
